/* File: fsp_cfg.svh */
// fsp_cfg.svh - constants of the flash self-programming controller
// assumes: included by bare name after the package, one 50 MHz clock
`ifndef FSP_CFG_SVH
`define FSP_CFG_SVH

// ----------------------------------------------------------------------
// control register field positions
// ----------------------------------------------------------------------
`define FSP_BIT_SPE        0
`define FSP_BIT_ERASE      1
`define FSP_BIT_PWRITE     2
`define FSP_BIT_LOCKSET    3
`define FSP_BIT_REEN       4
`define FSP_BIT_RWWBUSY    6
`define FSP_CMD_W          5

// ----------------------------------------------------------------------
// accepted command patterns in the lower five bits, and the cleared value
// ----------------------------------------------------------------------
`define FSP_PAT_REEN       5'h11
`define FSP_PAT_LOCK       5'h09
`define FSP_PAT_PWRITE     5'h05
`define FSP_PAT_LOAD       5'h01
`define FSP_CMD_RST        5'h00

// ----------------------------------------------------------------------
// pointer values selecting fuse and lock bytes
// ----------------------------------------------------------------------
`define FSP_Z_FUSE_LOW     16'h0000
`define FSP_Z_LOCK         16'h0001
`define FSP_Z_FUSE_EXT     16'h0002
`define FSP_Z_FUSE_HIGH    16'h0003

// ----------------------------------------------------------------------
// byte layouts and reset values
// ----------------------------------------------------------------------
`define FSP_LOCK_LSB       2
`define FSP_LOCK_MSB       5
`define FSP_ONES2          2'h3
`define FSP_ONES4          4'hF
`define FSP_BYTE_ONES      8'hFF
`define FSP_BYTE_ZERO      8'h00
`define FSP_WORD_ZERO      16'h0000

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define FSP_SPM_WIN        4
`define FSP_LPM_WIN        3
`define FSP_CLK_PERIOD_NS  20
`define FSP_OP_MIN_NS      3700000
`define FSP_OP_MAX_NS      4500000
`define FSP_OP_CYCLES      ((`FSP_OP_MIN_NS + `FSP_CLK_PERIOD_NS - 1) / `FSP_CLK_PERIOD_NS)

`endif

/* File: fsp_pkg.sv */
// fsp_pkg.sv - types shared by both ends of the self-programming link
// assumes: compiled before the interface and the modules
package fsp_pkg;

    // host-side command set
    typedef enum logic [2:0] {
        FSP_OP_LOAD   = 3'h0,
        FSP_OP_PWRITE = 3'h1,
        FSP_OP_LOCKWR = 3'h2,
        FSP_OP_REEN   = 3'h3,
        FSP_OP_READ   = 3'h4
    } fsp_cmd_t;

    // host sequencer states, one-hot
    typedef enum logic [4:0] {
        FSP_H_IDLE   = 5'h01,
        FSP_H_WAIT   = 5'h02,
        FSP_H_WRCTL  = 5'h04,
        FSP_H_ISSUE  = 5'h08,
        FSP_H_RESULT = 5'h10
    } fsp_hstate_t;

endpackage

/* File: fsp_if.sv */
// fsp_if.sv - link between cpu core and flash self-programming control
// assumes: one clock shared by both ends, all signals synchronous
`timescale 1ns/100ps
interface fsp_if;
    logic        ctl_wr;      // control register write strobe
    logic [7:0]  ctl_wdata;   // control register write data
    logic [7:0]  ctl_rdata;   // control register contents
    logic        spm_req;     // store-program instruction strobe
    logic        lpm_req;     // load-program instruction strobe
    logic [15:0] z_ptr;       // pointer register
    logic [15:0] spm_data;    // r0 operand
    logic [7:0]  lpm_data;    // load-program result
    logic        lpm_valid;   // result strobe
    logic        rww_block;   // read-while-write section not readable
    logic        ee_busy;     // eeprom write in progress

    modport dev  (input ctl_wr, ctl_wdata, spm_req, lpm_req, z_ptr, spm_data,
                  output ctl_rdata, lpm_data, lpm_valid, rww_block, ee_busy);
    modport host (output ctl_wr, ctl_wdata, spm_req, lpm_req, z_ptr, spm_data,
                  input ctl_rdata, lpm_data, lpm_valid, rww_block, ee_busy);
endinterface

/* File: fsp_dev.sv */
// fsp_dev.sv - flash self-programming control, device end
// assumes: cpu end on fsp_if, flash array and fuse storage on user ports
//
// Contract
// - page write blocks read-while-write section reads
// - busy flag high while section busy
// - software re-enables section before reading it
// - lock pattern plus store-program writes lock
// - zero bits in r0[5:2] program lock bits
// - pointer ignored; software pads r0 with ones
// - lock write leaves whole flash readable
// - eeprom write blocks programming and fuse reads
// - software checks eeprom busy before control write
// - armed load-program at 0x0001 returns lock bits
// - arm bits clear on read or timeout
// - unarmed load-program reads flash byte
// - armed read at 0x0000 returns fuse low
// - armed read at 0x0003 returns fuse high
// - armed read at 0x0002 returns extended fuse
// - programmed reads zero, unprogrammed reads one
// - write in progress survives reset
// - flash operations last 3.7 to 4.5 ms
// - software moves vectors or masks interrupts
// - enable arms store-program for four cycles
// - only accepted patterns change control bits
`timescale 1ns/100ps
`include "fsp_cfg.svh"

module fsp_dev
    import fsp_pkg::*;
#(
    parameter int CNT_W      = 18,
    parameter int OP_CYCLES  = `FSP_OP_CYCLES
) (
    // clock and resets
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        por,
    // cpu side
    fsp_if.dev               bus,
    // flash array and nonvolatile storage
    input  wire logic [7:0]  flash_byte,
    input  wire logic        ee_write_busy,
    input  wire logic [3:0]  lock_bits,
    input  wire logic [7:0]  fuse_low,
    input  wire logic [7:0]  fuse_high,
    input  wire logic [3:0]  fuse_ext,
    output logic             buf_load_q,
    output logic             page_write_q,
    output logic             lock_write_q,
    output logic [15:0]      op_addr_q,
    output logic [15:0]      op_data_q,
    output logic             op_busy_q
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (OP_CYCLES < 1 || OP_CYCLES >= (2 ** CNT_W))
        $error("fsp_dev: OP_CYCLES does not fit CNT_W");
    if (`FSP_SPM_WIN <= `FSP_LPM_WIN)
        $error("fsp_dev: load window must be shorter than store window");

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    localparam logic [CNT_W-1:0] OP_LOAD = CNT_W'(OP_CYCLES);
    localparam logic [2:0]       ARM_MAX = 3'(`FSP_SPM_WIN);
    localparam logic [2:0]       LPM_LIM = 3'(`FSP_SPM_WIN - `FSP_LPM_WIN);

    logic [`FSP_CMD_W-1:0] cmd_q;
    logic [2:0]            arm_q;
    logic                  rww_busy_q;
    logic [CNT_W-1:0]      op_cnt_q;
    logic                  op_page_q;
    logic                  ee_busy_q;
    logic [7:0]            ctl_rdata_q;
    logic [7:0]            lpm_data_q;
    logic                  lpm_valid_q;
    logic                  rww_block_q;

    // true when the written value is one of the accepted patterns
    function automatic logic pat_ok(input logic [`FSP_CMD_W-1:0] v);
        return (v == `FSP_PAT_REEN) || (v == `FSP_PAT_LOCK) ||
               (v == `FSP_PAT_PWRITE) || (v == `FSP_PAT_LOAD);
    endfunction

    // armed command decode, used by several processes
    function automatic logic is_cmd(input logic [`FSP_CMD_W-1:0] c,
                                    input logic [`FSP_CMD_W-1:0] pat);
        return c == pat;
    endfunction

    logic armed;
    logic op_run;
    logic ctl_take;
    logic spm_go;
    logic lpm_armed;
    logic op_done;

    assign armed     = (arm_q != 3'h0);
    assign op_run    = (op_cnt_q != '0);
    assign op_done   = (op_cnt_q == CNT_W'(1));
    // eeprom activity locks out every control write and armed read
    assign ctl_take  = bus.ctl_wr && !ee_busy_q && !op_run &&
                       pat_ok(bus.ctl_wdata[`FSP_CMD_W-1:0]);
    assign spm_go    = bus.spm_req && armed && !op_run;
    assign lpm_armed = bus.lpm_req && armed && (arm_q > LPM_LIM) && !ee_busy_q &&
                       is_cmd(cmd_q, `FSP_PAT_LOCK);

    // ------------------------------------------------------------------
    // eeprom busy, registered for the cpu and the lockout
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst || por) begin
            ee_busy_q <= 1'b0;
        end else begin
            ee_busy_q <= ee_write_busy;
        end
    end

    // ------------------------------------------------------------------
    // arm window: four cycles for store, first three for load
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst || por) begin
            arm_q <= 3'h0;
        end else if (ctl_take) begin
            arm_q <= ARM_MAX;
        end else if (spm_go || lpm_armed) begin
            arm_q <= 3'h0;
        end else if (armed) begin
            arm_q <= arm_q - 3'h1;
        end
    end

    // ------------------------------------------------------------------
    // command bits: held through a long operation, else auto-cleared
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (por) begin
            cmd_q <= `FSP_CMD_RST;
        end else if (op_run) begin
            if (op_done) begin
                cmd_q <= `FSP_CMD_RST;
            end
        end else if (rst) begin
            cmd_q <= `FSP_CMD_RST;
        end else if (ctl_take) begin
            cmd_q <= bus.ctl_wdata[`FSP_CMD_W-1:0];
        end else if (lpm_armed) begin
            cmd_q <= `FSP_CMD_RST;
        end else if (spm_go) begin
            if (!is_cmd(cmd_q, `FSP_PAT_PWRITE) && !is_cmd(cmd_q, `FSP_PAT_LOCK)) begin
                cmd_q <= `FSP_CMD_RST;
            end
        end else if (arm_q == 3'h1) begin
            cmd_q <= `FSP_CMD_RST;
        end
    end

    // ------------------------------------------------------------------
    // operation timer; only power-on stops it, so a reset mid-write
    // still lets the flash finish its cycle
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (por) begin
            op_cnt_q  <= '0;
            op_page_q <= 1'b0;
            op_addr_q <= `FSP_WORD_ZERO;
            op_data_q <= `FSP_WORD_ZERO;
        end else if (op_run) begin
            op_cnt_q <= op_cnt_q - CNT_W'(1);
        end else if (spm_go && is_cmd(cmd_q, `FSP_PAT_PWRITE)) begin
            op_cnt_q  <= OP_LOAD;
            op_page_q <= 1'b1;
            op_addr_q <= bus.z_ptr;
        end else if (spm_go && is_cmd(cmd_q, `FSP_PAT_LOCK)) begin
            op_cnt_q  <= OP_LOAD;
            op_page_q <= 1'b0;
            // new lock image: only zero bits program, pointer unused
            op_data_q <= {8'h00, `FSP_ONES2,
                          lock_bits & bus.spm_data[`FSP_LOCK_MSB:`FSP_LOCK_LSB],
                          `FSP_ONES2};
        end else if (spm_go && is_cmd(cmd_q, `FSP_PAT_LOAD)) begin
            op_addr_q <= bus.z_ptr;
            op_data_q <= bus.spm_data;
        end
    end

    // ------------------------------------------------------------------
    // strobes toward the flash array
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst || por) begin
            buf_load_q   <= 1'b0;
            page_write_q <= 1'b0;
            lock_write_q <= 1'b0;
        end else begin
            buf_load_q   <= spm_go && is_cmd(cmd_q, `FSP_PAT_LOAD);
            page_write_q <= spm_go && is_cmd(cmd_q, `FSP_PAT_PWRITE);
            lock_write_q <= spm_go && is_cmd(cmd_q, `FSP_PAT_LOCK);
        end
    end

    // ------------------------------------------------------------------
    // busy flag and read blocking; the flag waits for re-enable even
    // after the array is done, so software sees one clear handover
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (por) begin
            rww_busy_q  <= 1'b0;
            rww_block_q <= 1'b0;
            op_busy_q   <= 1'b0;
        end else begin
            op_busy_q <= op_run ? !op_done : spm_go &&
                         (is_cmd(cmd_q, `FSP_PAT_PWRITE) || is_cmd(cmd_q, `FSP_PAT_LOCK));
            if (spm_go && is_cmd(cmd_q, `FSP_PAT_PWRITE)) begin
                rww_busy_q  <= 1'b1;
                rww_block_q <= 1'b1;
            end else if (spm_go && is_cmd(cmd_q, `FSP_PAT_REEN)) begin
                rww_busy_q  <= 1'b0;
                rww_block_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // control register readback
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (por) begin
            ctl_rdata_q <= `FSP_BYTE_ZERO;
        end else begin
            ctl_rdata_q <= `FSP_BYTE_ZERO;
            ctl_rdata_q[`FSP_CMD_W-1:0]      <= cmd_q;
            ctl_rdata_q[`FSP_BIT_RWWBUSY]    <= rww_busy_q;
        end
    end

    // ------------------------------------------------------------------
    // load-program answer: fuse or lock byte when armed, else flash
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst || por) begin
            lpm_valid_q <= 1'b0;
            lpm_data_q  <= `FSP_BYTE_ZERO;
        end else begin
            lpm_valid_q <= bus.lpm_req;
            if (lpm_armed) begin
                // stored bits are already zero when programmed
                unique case (bus.z_ptr)
                    `FSP_Z_LOCK:      lpm_data_q <= {`FSP_ONES2, lock_bits,
                                                     `FSP_ONES2};
                    `FSP_Z_FUSE_LOW:  lpm_data_q <= fuse_low;
                    `FSP_Z_FUSE_HIGH: lpm_data_q <= fuse_high;
                    `FSP_Z_FUSE_EXT:  lpm_data_q <= {`FSP_ONES4, fuse_ext};
                    default:          lpm_data_q <= `FSP_BYTE_ONES;
                endcase
            end else if (bus.lpm_req) begin
                lpm_data_q <= flash_byte;
            end
        end
    end

    // ------------------------------------------------------------------
    // link outputs
    // ------------------------------------------------------------------
    assign bus.ctl_rdata = ctl_rdata_q;
    assign bus.lpm_data  = lpm_data_q;
    assign bus.lpm_valid = lpm_valid_q;
    assign bus.rww_block = rww_block_q;
    assign bus.ee_busy   = ee_busy_q;

endmodule // fsp_dev

/* File: fsp_host.sv */
// fsp_host.sv - cpu-side sequencer issuing self-programming steps
// assumes: device end on fsp_if, interrupts masked by the user
`timescale 1ns/100ps
`include "fsp_cfg.svh"

module fsp_host
    import fsp_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // link
    fsp_if.host              bus,
    // user command
    input  wire logic        cmd_valid,
    input  wire fsp_cmd_t    cmd_op,
    input  wire logic [15:0] cmd_z,
    input  wire logic [15:0] cmd_data,
    output logic             cmd_ready_q,
    output logic [7:0]       rd_data_q,
    output logic             rd_valid_q,
    output logic             rww_ok_q
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    fsp_hstate_t state_q;
    fsp_cmd_t    op_q;
    logic [15:0] z_q;
    logic [15:0] data_q;
    logic        ctl_wr_q;
    logic [7:0]  ctl_wdata_q;
    logic        spm_q;
    logic        lpm_q;

    // control pattern for each command
    function automatic logic [7:0] pat_of(input fsp_cmd_t op);
        unique case (op)
            FSP_OP_PWRITE: return {3'h0, `FSP_PAT_PWRITE};
            FSP_OP_LOCKWR: return {3'h0, `FSP_PAT_LOCK};
            FSP_OP_REEN:   return {3'h0, `FSP_PAT_REEN};
            FSP_OP_READ:   return {3'h0, `FSP_PAT_LOCK};
            default:       return {3'h0, `FSP_PAT_LOAD};
        endcase
    endfunction

    // ------------------------------------------------------------------
    // sequencer: wait idle, write control, issue one instruction
    // the very next cycle, so both arm windows are always met
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q     <= FSP_H_IDLE;
            op_q        <= FSP_OP_LOAD;
            z_q         <= `FSP_WORD_ZERO;
            data_q      <= `FSP_WORD_ZERO;
            ctl_wr_q    <= 1'b0;
            ctl_wdata_q <= `FSP_BYTE_ZERO;
            spm_q       <= 1'b0;
            lpm_q       <= 1'b0;
            cmd_ready_q <= 1'b1;
            rd_valid_q  <= 1'b0;
            rd_data_q   <= `FSP_BYTE_ZERO;
        end else begin
            ctl_wr_q   <= 1'b0;
            spm_q      <= 1'b0;
            lpm_q      <= 1'b0;
            rd_valid_q <= 1'b0;
            unique case (state_q)
                FSP_H_IDLE: begin
                    if (cmd_valid) begin
                        op_q        <= cmd_op;
                        z_q         <= cmd_z;
                        data_q      <= cmd_data;
                        cmd_ready_q <= 1'b0;
                        state_q     <= FSP_H_WAIT;
                    end
                end
                FSP_H_WAIT: begin
                    // previous step and eeprom both idle
                    if (!bus.ee_busy && !bus.ctl_rdata[`FSP_BIT_SPE]) begin
                        ctl_wr_q    <= 1'b1;
                        ctl_wdata_q <= pat_of(op_q);
                        state_q     <= FSP_H_WRCTL;
                    end
                end
                FSP_H_WRCTL: begin
                    spm_q   <= (op_q != FSP_OP_READ);
                    lpm_q   <= (op_q == FSP_OP_READ);
                    state_q <= FSP_H_ISSUE;
                end
                FSP_H_ISSUE: begin
                    state_q <= FSP_H_RESULT;
                end
                FSP_H_RESULT: begin
                    if (op_q == FSP_OP_READ) begin
                        rd_data_q  <= bus.lpm_data;
                        rd_valid_q <= 1'b1;
                    end
                    cmd_ready_q <= 1'b1;
                    state_q     <= FSP_H_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // section readable only once the busy flag is cleared
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rww_ok_q <= 1'b0;
        end else begin
            rww_ok_q <= !bus.ctl_rdata[`FSP_BIT_RWWBUSY] && !bus.rww_block;
        end
    end

    // ------------------------------------------------------------------
    // link outputs
    // ------------------------------------------------------------------
    assign bus.ctl_wr    = ctl_wr_q;
    assign bus.ctl_wdata = ctl_wdata_q;
    assign bus.spm_req   = spm_q;
    assign bus.lpm_req   = lpm_q;
    assign bus.z_ptr     = z_q;
    assign bus.spm_data  = data_q;

endmodule // fsp_host

/* File: fsp_chk.sv */
// fsp_chk.sv - assertions on the link between host end and device end
// assumes: instanced beside fsp_if in the bench, one clock, por raised with rst at start, rst also raised alone
`timescale 1ns/100ps
module fsp_chk (
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       rst,
    // link signals
    input wire logic       ctl_wr,
    input wire logic [7:0] ctl_wdata,
    input wire logic [7:0] ctl_rdata,
    input wire logic       spm_req,
    input wire logic       lpm_req,
    input wire logic       lpm_valid,
    input wire logic       rww_block,
    input wire logic       ee_busy
);
    // rst alone leaves busy state alive, yet every assertion is fenced off while rst is high
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    a_valid_follows: assert property (lpm_req |=> lpm_valid)
        else $error("result strobe missing after load request");
    a_valid_cause: assert property (lpm_valid |-> $past(lpm_req))
        else $error("result strobe without a load request");
    a_block_set: assert property ((ctl_wr && ctl_wdata[4:0] == 5'h05 && !ee_busy
        && !ctl_rdata[6]) ##1 spm_req |=> rww_block) else $error("page write left section open");
    a_block_holds: assert property (rww_block && !spm_req |=> rww_block)
        else $error("section unblocked without re-enable");
    a_flag_mirror: assert property (rww_block [*2] |-> ctl_rdata[6])
        else $error("busy flag low while section blocked");
    a_lock_open: assert property ((ctl_wr && ctl_wdata[4:0] == 5'h09 && !rww_block)
        ##1 spm_req |=> !rww_block [*3]) else $error("lock write blocked the section");
    a_arm_clear: assert property ((ctl_wr && ctl_wdata[4:0] == 5'h09) ##1 lpm_req
        |-> ##2 ctl_rdata[4:0] == 5'h00) else $error("arm bits kept after read");
    a_ee_refuse: assert property (ee_busy && ctl_wr && ctl_rdata[4:0] == 5'h00
        |-> ##2 ctl_rdata[4:0] == 5'h00) else $error("control write taken during eeprom write");
    // main scenarios reached
    c_blocked: cover property (rww_block [*2]);
    c_read: cover property (lpm_valid);
    c_lock: cover property (ctl_wr && ctl_wdata[4:0] == 5'h09);
endmodule // fsp_chk

/* File: flash_self_program_control_tb.sv */
// flash_self_program_control_tb.sv - bench joining host end and device end
// assumes: fsp_pkg, fsp_if, fsp_dev, fsp_host and fsp_chk compiled first
// no interrupt source in the bench, so the host never needs masking
`timescale 1ns/100ps
module flash_self_program_control_tb;
    import fsp_pkg::*;
    // short timer keeps the run brief; the end-of-operation waits derive from it
    localparam int OPC = 20;
    localparam logic [7:0] FLO = 8'h5C;
    localparam logic [7:0] FHI = 8'hD9;
    localparam logic [3:0] FEX = 4'h6;
    logic clk_sys = 1'b0, rst = 1'b1, por = 1'b1, ee_wb = 1'b0, cmd_valid = 1'b0;
    fsp_cmd_t    cmd_op = FSP_OP_READ;
    logic [15:0] cmd_z = 16'h0000, cmd_data = 16'h0000, op_data_q, op_addr_q;
    logic [7:0]  rd_data_q;
    logic        cmd_ready_q, rd_valid_q, rww_ok_q, lock_write_q, op_busy_q, buf_load_q;
    int          bad_count = 0, checks_done = 0, cycles = 0;
    fsp_if lnk ();
    fsp_dev #(.OP_CYCLES(OPC)) i_fsp_dev (.clk_sys(clk_sys), .rst(rst), .por(por), .bus(lnk.dev),
        .flash_byte(8'h3E), .ee_write_busy(ee_wb), .lock_bits(4'hB), .fuse_low(FLO),
        .fuse_high(FHI), .fuse_ext(FEX), .buf_load_q(buf_load_q), .page_write_q(),
        .lock_write_q(lock_write_q), .op_addr_q(op_addr_q), .op_data_q(op_data_q),
        .op_busy_q(op_busy_q));
    fsp_host i_fsp_host (.clk_sys(clk_sys), .rst(rst), .bus(lnk.host), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_z(cmd_z), .cmd_data(cmd_data), .cmd_ready_q(cmd_ready_q),
        .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .rww_ok_q(rww_ok_q));
    fsp_chk i_fsp_chk (.clk_sys(clk_sys), .rst(rst), .ctl_wr(lnk.ctl_wr),
        .ctl_wdata(lnk.ctl_wdata), .ctl_rdata(lnk.ctl_rdata), .spm_req(lnk.spm_req),
        .lpm_req(lnk.lpm_req), .lpm_valid(lnk.lpm_valid), .rww_block(lnk.rww_block),
        .ee_busy(lnk.ee_busy));
    // ------------------------------------------------------------------
    // clock, hang guard and shared tasks
    // ------------------------------------------------------------------
    always #10 clk_sys = ~clk_sys;
    // about 115 cycles expected; the ceiling cuts a hung handshake
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one command through the host; valid held over exactly one taking edge
    task automatic run(input fsp_cmd_t op, input logic [15:0] z, input logic [15:0] d);
        int n = 0;
        while (cmd_ready_q !== 1'b1 && n < 60) begin
            @(negedge clk_sys);
            n++;
        end
        cmd_op    = op;
        cmd_z     = z;
        cmd_data  = d;
        cmd_valid = 1'b1;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
    endtask
    task automatic wait_rd(input logic [7:0] exp);
        int n = 0;
        while (rd_valid_q !== 1'b1 && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
        check("read strobe", {15'h0, rd_valid_q}, 16'h0001);
        check("read byte", {8'h00, rd_data_q}, {8'h00, exp});
    endtask
    // lone enable: the store lands in the page buffer, no timer
    task automatic t_buf_load();
        int n = 0;
        run(FSP_OP_LOAD, 16'h0012, 16'hA55A);
        while (buf_load_q !== 1'b1 && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
        check("buffer word", op_data_q, 16'hA55A);
        check("buffer address", op_addr_q, 16'h0012);
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_fuse_reads();
        run(FSP_OP_READ, 16'h0000, 16'h0000);
        wait_rd(FLO);
        run(FSP_OP_READ, 16'h0001, 16'h0000);
        wait_rd(8'hEF);
        run(FSP_OP_READ, 16'h0002, 16'h0000);
        wait_rd({4'hF, FEX});
        run(FSP_OP_READ, 16'h0003, 16'h0000);
        wait_rd(FHI);
    endtask
    // r0 bits 5..2 = 1101 programs one more lock bit; pads stay ones
    task automatic t_lock_write();
        int n = 0;
        run(FSP_OP_LOCKWR, 16'h0001, 16'h00F7);
        while (lock_write_q !== 1'b1 && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
        check("lock strobe", {15'h0, lock_write_q}, 16'h0001);
        check("lock image", op_data_q & 16'h00FF, 16'h00E7);
        check("lock keeps flash open", {15'h0, lnk.rww_block}, 16'h0000);
        repeat (OPC + 4) @(negedge clk_sys);
    endtask
    // page write, reset in mid-operation, then re-enable
    task automatic t_page_write();
        run(FSP_OP_PWRITE, 16'h0040, 16'h0000);
        repeat (4) @(negedge clk_sys);
        check("section blocked", {15'h0, lnk.rww_block}, 16'h0001);
        check("busy flag", {15'h0, lnk.ctl_rdata[6]}, 16'h0001);
        check("host holds off", {15'h0, rww_ok_q}, 16'h0000);
        rst = 1'b1;
        @(negedge clk_sys);
        rst = 1'b0;
        check("write survives reset", {15'h0, op_busy_q}, 16'h0001);
        repeat (OPC + 4) @(negedge clk_sys);
        check("timer ended", {15'h0, op_busy_q}, 16'h0000);
        check("still blocked", {15'h0, lnk.rww_block}, 16'h0001);
        run(FSP_OP_REEN, 16'h0000, 16'h0000);
        repeat (5) @(negedge clk_sys);
        check("section reopened", {15'h0, lnk.rww_block}, 16'h0000);
        check("host may read", {15'h0, rww_ok_q}, 16'h0001);
    endtask
    task automatic t_ee_block();
        ee_wb = 1'b1;
        run(FSP_OP_READ, 16'h0000, 16'h0000);
        repeat (10) @(negedge clk_sys);
        check("no arm during eeprom write", {11'h0, lnk.ctl_rdata[4:0]}, 16'h0000);
        ee_wb = 1'b0;
        wait_rd(FLO);
    endtask
    // eeprom write starts just after the host's own check: device refuses
    task automatic t_ee_late();
        run(FSP_OP_READ, 16'h0000, 16'h0000);
        ee_wb = 1'b1;
        wait_rd(8'h3E);
        check("late arm refused", {11'h0, lnk.ctl_rdata[4:0]}, 16'h0000);
        ee_wb = 1'b0;
    endtask
    initial begin
        repeat (5) @(negedge clk_sys);
        rst = 1'b0;
        por = 1'b0;
        t_fuse_reads();
        t_buf_load();
        t_lock_write();
        t_page_write();
        t_ee_block();
        t_ee_late();
        give_verdict();
    end
endmodule // flash_self_program_control_tb
